// ---- core/ics_core_ctl.sv ----
// Purpose: working register mapping, stack pointer, interrupt priority, entry and return
// Assumes: all strobes come from core logic on CLK; fuse and lock levels are pins
// Notes:   memory arrays and alu flags live elsewhere
//
// Contract
// RL1 - working registers occupy data addresses 0..31 in register order
// RL2 - registers 26..31 form three 16-bit pointers, low byte first
// RL3 - push decrements stack pointer by one, pop increments by one
// RL4 - calls and interrupt entry subtract two; returns add two
// RL5 - stack pointer lives in low and high io bytes, three high bits used
// RL6 - software sets the stack pointer before calls or enabling interrupts
// RL7 - stack pointer starts at the last internal sram address after reset
// RL8 - two-register alu result is written back in one clock
// RL9 - each source has its own vector; lower vector means higher priority
// RL10 - a source is live only with its enable and global enable set
// RL11 - programmed lock bits block interrupts depending on program counter
// RL12 - vector select moves vectors to boot start; fuse moves reset vector
// RL13 - entry clears global enable; software may set it; return sets it
// RL14 - vectoring clears the taken flag; writing one clears a flag
// RL15 - disabled flags stay pending, later served by priority
// RL16 - level sources request only while their condition holds
// RL17 - one instruction runs after return before another interrupt
// RL18 - clearing global enable blocks even a same-cycle interrupt
// RL19 - one instruction runs after setting global enable before interrupts
// RL20 - entry takes four clocks pushing the pc, after the current instruction
// RL21 - waking from sleep adds four clocks to entry
// RL22 - return takes four clocks, adds two to pointer, sets global enable
// RL23 - global enable is status bit 7; status is never saved automatically
`timescale 1ns/1ps
module ics_core_ctl #(
  parameter int               N_IRQ      = 8,
  parameter logic [N_IRQ-1:0] LEVEL_MASK = '0,
  parameter logic [15:0]      BOOT_START = 16'h1e00
) (
  input  wire logic             CLK,
  input  wire logic             RSTN,
  input  wire logic [15:0]      DS_ADDR,
  input  wire logic             DS_WE,
  input  wire logic             DS_RE,
  input  wire logic [7:0]       DS_WDATA,
  output logic      [7:0]       DS_RDATA,
  output logic                  DS_HIT,
  input  wire logic             ALU_GO,
  input  wire logic [1:0]       ALU_OP,
  input  wire logic [4:0]       ALU_DST,
  input  wire logic [4:0]       ALU_SRC,
  input  wire logic             PTR_GO,
  input  wire logic [1:0]       PTR_SEL,
  input  wire logic [1:0]       PTR_MODE,
  input  wire logic [5:0]       PTR_DISP,
  output logic      [15:0]      PTR_ADDR,
  input  wire logic             STK_PUSH,
  input  wire logic             STK_POP,
  input  wire logic             STK_CALL,
  input  wire logic             STK_RET,
  input  wire logic             STK_RETURN_FROM_INTERRUPT_INSTR,
  output logic      [10:0]      SP,
  input  wire logic             GIE_SET,
  input  wire logic             GIE_CLR,
  output logic                  GIE,
  input  wire logic             INSTR_DONE,
  input  wire logic             SLEEPING,
  input  wire logic [15:0]      PC,
  input  wire logic [N_IRQ-1:0] IRQ_EVT,
  input  wire logic [N_IRQ-1:0] IRQ_LVL,
  input  wire logic [N_IRQ-1:0] IRQ_EN,
  input  wire logic [N_IRQ-1:0] IRQ_FLAG_CLR,
  output logic      [N_IRQ-1:0] IRQ_FLAGS,
  input  wire logic             VECTOR_SELECT_BIT,
  input  wire logic             BOOT_RESET_FUSE,
  input  wire logic             APPLICATION_LOCK_BIT,
  input  wire logic             BOOT_LOCK_BIT,
  output logic                  CORE_HOLD,
  output logic                  IRQ_ENTER,
  output logic      [15:0]      VEC_ADDR,
  output logic      [15:0]      RESET_VEC
);
  localparam int IW = (N_IRQ > 1) ? $clog2(N_IRQ) : 1;

  ics_pkg::ics_state_e st_q, st_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [10:0]      sp_q, sp_d;
  logic [7:0]       stat_q, stat_d;
  logic [N_IRQ-1:0] flag_q, flag_d;
  logic             hold_one_q;
  logic [2:0]       pin_s1_q, pin_s2_q;
  logic [7:0]       rdata_q;
  logic             hit_q;
  logic [15:0]      paddr_q, vec_q, rvec_q;
  logic             busy_q, enter_q;

  function automatic logic [IW-1:0] first_set(input logic [N_IRQ-1:0] v);
    first_set = '0;
    for (int i = N_IRQ - 1; i >= 0; i--)
      if (v[i])
        first_set = IW'(i);
  endfunction : first_set

  // register file and pointer unit
  ics_rf_if rf ();
  ics_regfile u_rf (
    .clk  (CLK),
    .rstn (RSTN),
    .rf   (rf.file)
  );

  wire [15:0] ea_w;
  wire [15:0] pnext_w;
  wire        pwr_w;
  ics_ptr u_ptr (
    .ptr      (rf.pa_data),
    .mode     (ics_pkg::ics_pmode_e'(PTR_MODE)),
    .disp     (PTR_DISP),
    .ea       (ea_w),
    .ptr_next (pnext_w),
    .wr       (pwr_w)
  );

  // data-space decode
  wire       ds_rf_w  = DS_ADDR < ics_pkg::WREG_END;  // RL1
  wire       ds_io_w  = DS_ADDR >= ics_pkg::IO_BASE && DS_ADDR < ics_pkg::IO_END;
  wire [5:0] io_ofs_w = 6'(DS_ADDR - ics_pkg::IO_BASE);
  wire       spl_w    = ds_io_w && io_ofs_w == ics_pkg::SPL_OFS;
  wire       sph_w    = ds_io_w && io_ofs_w == ics_pkg::SPH_OFS;
  wire       stat_w   = ds_io_w && io_ofs_w == ics_pkg::STAT_OFS;
  wire       hit_w    = ds_rf_w || spl_w || sph_w || stat_w;

  // alu: operands read and result written back on the same edge
  wire [7:0] alu_a_w = rf.ra_data;
  wire [7:0] alu_b_w = rf.rb_data;
  wire [7:0] alu_r_w = (ALU_OP == 2'h0) ? alu_a_w + alu_b_w :
                       (ALU_OP == 2'h1) ? alu_a_w - alu_b_w :
                       (ALU_OP == 2'h2) ? alu_a_w & alu_b_w : alu_b_w;  // RL8

  assign rf.ra_addr = ALU_DST;
  assign rf.rb_addr = ALU_GO ? ALU_SRC : DS_ADDR[4:0];
  assign rf.pa_sel  = PTR_SEL;
  // alu wins the byte port; core never pairs an alu op with a data write
  assign rf.bw_en   = ALU_GO || (DS_WE && ds_rf_w);  // RL8
  assign rf.bw_addr = ALU_GO ? ALU_DST : DS_ADDR[4:0];  // RL1
  assign rf.bw_data = ALU_GO ? alu_r_w : DS_WDATA;
  assign rf.ww_en   = PTR_GO && pwr_w;  // RL2
  assign rf.ww_sel  = PTR_SEL;
  assign rf.ww_data = pnext_w;

  wire [7:0] rdata_w = ds_rf_w ? rf.rb_data :
                       spl_w   ? sp_q[7:0] :
                       sph_w   ? {5'h00, sp_q[10:8]} :
                       stat_w  ? stat_q : 8'h00;  // RL5

  // interrupt request, priority and blocking
  wire [N_IRQ-1:0] req_w      = IRQ_EN & ((LEVEL_MASK & IRQ_LVL) | (~LEVEL_MASK & flag_q));
  wire             any_req_w  = |req_w;  // RL10 RL16
  wire [IW-1:0]    sel_idx_w  = first_set(req_w);  // RL9 RL15
  wire [N_IRQ-1:0] sel_hot_w  = N_IRQ'(1) << sel_idx_w;
  wire [N_IRQ-1:0] low_mask_w = sel_hot_w - N_IRQ'(1);
  wire             app_lk_w   = pin_s2_q[1];
  wire             boot_lk_w  = pin_s2_q[0];
  wire             pc_boot_w  = PC >= BOOT_START;
  wire             lock_blk_w = (!pc_boot_w && app_lk_w && VECTOR_SELECT_BIT) ||
                                (pc_boot_w && boot_lk_w && !VECTOR_SELECT_BIT);  // RL11
  wire [15:0]      vec_base_w = VECTOR_SELECT_BIT ? BOOT_START : ics_pkg::VEC_RESET;  // RL12
  wire [15:0]      vec_w      = vec_base_w + (16'(sel_idx_w) + 16'h0001) * ics_pkg::VEC_STRIDE;
  wire             gie_w      = stat_q[ics_pkg::GIE_BIT];  // RL23
  // sleeping core has no instruction in flight, so it may be entered at once
  wire             bound_w    = INSTR_DONE || SLEEPING;  // RL20
  wire             take_w     = st_q == ics_pkg::ST_RUN && bound_w && gie_w && !GIE_CLR &&
                                !hold_one_q && any_req_w && !lock_blk_w;  // RL10 RL18
  wire             return_from_interrupt_instr_go_w  = st_q == ics_pkg::ST_RUN && STK_RETURN_FROM_INTERRUPT_INSTR && !take_w;
  wire             cnt_zero_w = cnt_q == 4'h0;
  wire             entry_end_w = st_q == ics_pkg::ST_ENTRY && cnt_zero_w;
  wire             return_from_interrupt_instr_end_w = st_q == ics_pkg::ST_RETURN_FROM_INTERRUPT_INSTR && cnt_zero_w;
  wire [3:0]       entry_len_w = SLEEPING ? ics_pkg::ENTRY_CYC + ics_pkg::SLEEP_CYC - 4'h1 :
                                 ics_pkg::ENTRY_CYC - 4'h1;  // RL20 RL21

  // flags: a new event beats both clears in the same cycle
  wire [N_IRQ-1:0] hw_clr_w = take_w ? (sel_hot_w & ~LEVEL_MASK) : '0;  // RL14
  assign flag_d = (flag_q & ~(IRQ_FLAG_CLR | hw_clr_w)) | (IRQ_EVT & ~LEVEL_MASK);  // RL14 RL15

  // status register; global enable is not stacked on entry or return
  wire       stat_wr_w = stat_w && DS_WE;
  wire [7:0] stat_b_w  = stat_wr_w ? DS_WDATA : stat_q;  // RL23
  wire       gie_set_w = GIE_SET || return_from_interrupt_instr_end_w;  // RL13 RL22
  wire       gie_clr_w = GIE_CLR || take_w;  // RL13 RL18
  wire       gie_new_w = !gie_clr_w && (gie_set_w || stat_b_w[ics_pkg::GIE_BIT]);
  assign stat_d = (stat_b_w & ~ics_pkg::GIE_MASK) | (gie_new_w ? ics_pkg::GIE_MASK : 8'h00);

  // stack pointer; software writes win over stack traffic
  wire sp_down2_w = take_w || STK_CALL;  // RL4 RL20
  wire sp_up2_w   = return_from_interrupt_instr_go_w || STK_RET;  // RL4 RL22
  wire sp_sw_w    = DS_WE && (spl_w || sph_w);
  assign sp_d = (DS_WE && spl_w) ? {sp_q[10:8], DS_WDATA} :
                (DS_WE && sph_w) ? {DS_WDATA[2:0], sp_q[7:0]} :  // RL5
                sp_down2_w ? sp_q - ics_pkg::CALL_STEP :
                sp_up2_w   ? sp_q + ics_pkg::CALL_STEP :  // RL4
                STK_PUSH   ? sp_q - ics_pkg::PUSH_STEP :
                STK_POP    ? sp_q + ics_pkg::PUSH_STEP : sp_q;  // RL3

  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      ics_pkg::ST_RUN:
      begin
        if (take_w)
        begin
          st_d  = ics_pkg::ST_ENTRY;
          cnt_d = entry_len_w;  // RL20 RL21
        end
        else if (return_from_interrupt_instr_go_w)
        begin
          st_d  = ics_pkg::ST_RETURN_FROM_INTERRUPT_INSTR;
          cnt_d = ics_pkg::RETURN_FROM_INTERRUPT_INSTR_CYC - 4'h1;  // RL22
        end
      end
      ics_pkg::ST_ENTRY, ics_pkg::ST_RETURN_FROM_INTERRUPT_INSTR:
      begin
        if (cnt_zero_w)
          st_d = ics_pkg::ST_RUN;
        else
          cnt_d = cnt_q - 4'h1;
      end
      default:
      begin
        st_d  = ics_pkg::ST_RUN;
        cnt_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_q     <= ics_pkg::ST_RUN;
      cnt_q    <= 4'h0;
      sp_q     <= ics_pkg::SP_INIT;  // RL7
      stat_q   <= ics_pkg::STAT_RESET;
      flag_q   <= '0;
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end
    else
    begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      sp_q     <= sp_d;
      stat_q   <= stat_d;
      flag_q   <= flag_d;
      pin_s1_q <= {BOOT_RESET_FUSE, APPLICATION_LOCK_BIT, BOOT_LOCK_BIT};
      pin_s2_q <= pin_s1_q;
    end
  end

  // after return or enable, let exactly one instruction finish first
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      hold_one_q <= 1'b0;
    else if (gie_set_w)
      hold_one_q <= 1'b1;  // RL17 RL19
    else if (INSTR_DONE)
      hold_one_q <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
      paddr_q <= 16'h0000;
      vec_q   <= 16'h0000;
      rvec_q  <= ics_pkg::VEC_RESET;
      busy_q  <= 1'b0;
      enter_q <= 1'b0;
    end
    else
    begin
      rdata_q <= DS_RE ? rdata_w : rdata_q;
      hit_q   <= (DS_RE || DS_WE) && hit_w;
      paddr_q <= PTR_GO ? ea_w : paddr_q;
      vec_q   <= take_w ? vec_w : vec_q;  // RL9 RL12
      rvec_q  <= pin_s2_q[2] ? BOOT_START : ics_pkg::VEC_RESET;  // RL12
      busy_q  <= st_d != ics_pkg::ST_RUN;
      enter_q <= entry_end_w;  // RL20
    end
  end

  assign DS_RDATA  = rdata_q;
  assign DS_HIT    = hit_q;
  assign PTR_ADDR  = paddr_q;
  assign SP        = sp_q;
  assign GIE       = stat_q[ics_pkg::GIE_BIT];
  assign IRQ_FLAGS = flag_q;
  assign CORE_HOLD = busy_q;
  assign IRQ_ENTER = enter_q;
  assign VEC_ADDR  = vec_q;
  assign RESET_VEC = rvec_q;

  wire sp_quiet_w = !sp_sw_w && !take_w && !STK_CALL && !return_from_interrupt_instr_go_w && !STK_RET;

  a_push_dec : assert property (@(posedge CLK) disable iff (!RSTN) // RL3
    (STK_PUSH && sp_quiet_w) |=> SP == $past(SP) - 11'h001)
    else $error("push did not lower stack pointer by one");
  a_call_dec : assert property (@(posedge CLK) disable iff (!RSTN) // RL4
    (STK_CALL && !sp_sw_w) |=> SP == $past(SP) - 11'h002)
    else $error("call did not lower stack pointer by two");
  a_entry_sp : assert property (@(posedge CLK) disable iff (!RSTN) // RL20
    (take_w && !sp_sw_w) |=> (SP == $past(SP) - 11'h002) && !GIE)
    else $error("entry did not push pc or clear enable");
  a_entry_len : assert property (@(posedge CLK) disable iff (!RSTN) // RL20
    (take_w && !SLEEPING) |=> CORE_HOLD [*4] ##1 (IRQ_ENTER && !CORE_HOLD))
    else $error("entry did not last four cycles");
  a_sleep_len : assert property (@(posedge CLK) disable iff (!RSTN) // RL21
    (take_w && SLEEPING) |=> CORE_HOLD [*8] ##1 IRQ_ENTER)
    else $error("wake entry did not last eight cycles");
  a_return_from_interrupt_instr_seq : assert property (@(posedge CLK) disable iff (!RSTN) // RL22
    return_from_interrupt_instr_go_w |=> CORE_HOLD [*4] ##1 (!CORE_HOLD && GIE))
    else $error("return did not take four cycles and set enable");
  a_cli_block : assert property (@(posedge CLK) disable iff (!RSTN) // RL18
    GIE_CLR |-> !take_w ##1 !GIE)
    else $error("interrupt taken across enable clear");
  a_one_instr : assert property (@(posedge CLK) disable iff (!RSTN) // RL17
    return_from_interrupt_instr_end_w |=> !take_w until_with INSTR_DONE)
    else $error("interrupt taken before one instruction after return");
  a_prio_low : assert property (@(posedge CLK) disable iff (!RSTN) // RL9
    take_w |-> ((req_w & low_mask_w) == '0) ##1 VEC_ADDR == $past(vec_w))
    else $error("lower vector was pending but not chosen");
  a_flag_set : assert property (@(posedge CLK) disable iff (!RSTN) // RL14
    (|(IRQ_EVT & ~LEVEL_MASK)) |=>
      ((IRQ_FLAGS & $past(IRQ_EVT & ~LEVEL_MASK)) == $past(IRQ_EVT & ~LEVEL_MASK)))
    else $error("event lost against a flag clear");
endmodule : ics_core_ctl

// ---- core/ics_pkg.sv ----
// Purpose: shared constants and types for the core interrupt and stack control block
// Assumes: 50 MHz core clock, single clock domain
// Notes:   data-space addresses are byte addresses; io offsets are relative to io base
package ics_pkg;
  localparam int          SP_W        = 11;
  localparam int          NUM_WREG    = 32;
  localparam logic [15:0] WREG_END    = 16'h0020;
  localparam logic [15:0] IO_BASE     = 16'h0020;
  localparam logic [15:0] IO_END      = 16'h0060;
  localparam logic [5:0]  SPL_OFS     = 6'h3d;
  localparam logic [5:0]  SPH_OFS     = 6'h3e;
  localparam logic [5:0]  STAT_OFS    = 6'h3f;
  localparam int          GIE_BIT     = 7;
  localparam logic [7:0]  GIE_MASK    = 8'h80;
  localparam logic [7:0]  STAT_RESET  = 8'h00;
  // last internal sram address of the smallest memory size
  localparam logic [10:0] SP_INIT     = 11'h4ff;
  localparam logic [10:0] PUSH_STEP   = 11'h001;
  localparam logic [10:0] CALL_STEP   = 11'h002;
  localparam logic [4:0]  PTR_BASE    = 5'h1a;
  localparam logic [3:0]  ENTRY_CYC   = 4'h4;
  localparam logic [3:0]  SLEEP_CYC   = 4'h4;
  localparam logic [3:0]  RETURN_FROM_INTERRUPT_INSTR_CYC    = 4'h4;
  localparam logic [15:0] VEC_STRIDE  = 16'h0002;
  localparam logic [15:0] VEC_RESET   = 16'h0000;

  typedef enum logic [1:0] {ST_RUN, ST_ENTRY, ST_RETURN_FROM_INTERRUPT_INSTR} ics_state_e;
  typedef enum logic [1:0] {PM_DISP, PM_POSTINC, PM_PREDEC} ics_pmode_e;
  typedef enum logic [1:0] {AL_ADD, AL_SUB, AL_AND, AL_MOV} ics_aluop_e;
endpackage : ics_pkg

// ---- core/ics_rf_if.sv ----
// Purpose: connection between control core and working register file
// Assumes: combinational read ports, clocked write ports
// Notes:   word port writes one pointer pair, low byte at the lower register
`timescale 1ns/1ps
interface ics_rf_if;
  logic [4:0]  ra_addr;
  logic [4:0]  rb_addr;
  logic [7:0]  ra_data;
  logic [7:0]  rb_data;
  logic [1:0]  pa_sel;
  logic [15:0] pa_data;
  logic        bw_en;
  logic [4:0]  bw_addr;
  logic [7:0]  bw_data;
  logic        ww_en;
  logic [1:0]  ww_sel;
  logic [15:0] ww_data;

  modport core (output ra_addr, rb_addr, pa_sel, bw_en, bw_addr, bw_data, ww_en, ww_sel,
                ww_data, input ra_data, rb_data, pa_data);
  modport file (input ra_addr, rb_addr, pa_sel, bw_en, bw_addr, bw_data, ww_en, ww_sel,
                ww_data, output ra_data, rb_data, pa_data);
endinterface : ics_rf_if

// ---- core/ics_ptr.sv ----
// Purpose: effective address and update for one 16-bit pointer pair
// Assumes: displacement is unsigned, 0..63
// Notes:   purely combinational
`timescale 1ns/1ps
module ics_ptr (
  input  wire logic [15:0]        ptr,
  input  wire ics_pkg::ics_pmode_e mode,
  input  wire logic [5:0]         disp,
  output logic [15:0]             ea,
  output logic [15:0]             ptr_next,
  output logic                    wr
);
  wire [15:0] inc_w = ptr + 16'h0001;
  wire [15:0] dec_w = ptr - 16'h0001;
  wire [15:0] dsp_w = ptr + {10'h000, disp};

  // predecrement uses the new value, postincrement the old one
  assign ea       = (mode == ics_pkg::PM_DISP) ? dsp_w :
                    (mode == ics_pkg::PM_PREDEC) ? dec_w : ptr;  // RL2
  assign ptr_next = (mode == ics_pkg::PM_POSTINC) ? inc_w :
                    (mode == ics_pkg::PM_PREDEC) ? dec_w : ptr;  // RL2
  assign wr       = (mode != ics_pkg::PM_DISP);
endmodule : ics_ptr

// ---- core/ics_regfile.sv ----
// Purpose: 32 x 8 working registers held in flip-flops
// Assumes: word write has priority over byte write to the same register
// Notes:   two byte reads and one pointer-pair read, all combinational
`timescale 1ns/1ps
module ics_regfile (
  input  wire logic clk,
  input  wire logic rstn,
  ics_rf_if.file    rf
);
  logic [7:0] mem_q [ics_pkg::NUM_WREG];

  function automatic logic [4:0] pair_lo(input logic [1:0] sel);
    pair_lo = ics_pkg::PTR_BASE + {2'b00, sel, 1'b0};
  endfunction : pair_lo

  wire [4:0] wlo_w = pair_lo(rf.ww_sel);
  wire [4:0] plo_w = pair_lo(rf.pa_sel);

  assign rf.ra_data = mem_q[rf.ra_addr];
  assign rf.rb_data = mem_q[rf.rb_addr];
  assign rf.pa_data = {mem_q[plo_w | 5'h01], mem_q[plo_w]};  // RL2

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < ics_pkg::NUM_WREG; i++)
        mem_q[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < ics_pkg::NUM_WREG; i++)
      begin
        if (rf.ww_en && 5'(i) == wlo_w)
          mem_q[i] <= rf.ww_data[7:0];
        else if (rf.ww_en && 5'(i) == (wlo_w | 5'h01))
          mem_q[i] <= rf.ww_data[15:8];
        else if (rf.bw_en && 5'(i) == rf.bw_addr)
          mem_q[i] <= rf.bw_data;
      end
    end
  end
endmodule : ics_regfile

// ---- bench/ics_irq_src.sv ----
// Purpose: model of the peripheral interrupt sources beside the core
// Assumes: one event pulse per fire request, level follows its condition
// Notes:   no flag storage here, the core keeps pending state
`timescale 1ns/1ps
module ics_irq_src #(
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] fire,
  input  wire logic [N-1:0] cond,
  output logic      [N-1:0] evt,
  output logic      [N-1:0] lvl
);
  // registered so a request never lands in the edge that raised it
  always_ff @(posedge clk)
  begin
    evt <= fire;
  end
  // no latch: the request vanishes as soon as the condition does
  assign lvl = cond;
endmodule : ics_irq_src

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the core interrupt and stack control block
// Assumes: program counter stays in the application section throughout
// Notes:   boot-section lock branch is checked neither here nor by the in-design assertions
`timescale 1ns/1ps
module tb;
  localparam logic [9:0] PU = 10'h001, RI = 10'h010, SE = 10'h020, CL = 10'h040;
  localparam logic [9:0] ID = 10'h080, AG = 10'h100, PG = 10'h200;
  logic        clk, rstn, ds_we, ds_re, hit, gie, sleeping, vsel;
  logic        fuse, alock, blk, hold, enter;
  logic [9:0]  pls;
  logic [15:0] ds_addr, pc, ptr_addr, vec, rvec;
  logic [7:0]  ds_wdata, rdata, irq_en, flag_clr, fire, cond, evt, lvl, flags;
  logic [1:0]  alu_op, ptr_sel, ptr_mode;
  logic [4:0]  alu_dst, alu_src;
  logic [5:0]  ptr_disp;
  logic [10:0] sp, e;
  int          error_cnt, checks;
  ics_irq_src #(.N(8)) i_src (.clk(clk), .fire(fire), .cond(cond), .evt(evt), .lvl(lvl));
  ics_core_ctl #(.LEVEL_MASK(8'h80)) i_dut (
    .CLK(clk), .RSTN(rstn), .DS_ADDR(ds_addr), .DS_WE(ds_we), .DS_RE(ds_re),
    .DS_WDATA(ds_wdata), .DS_RDATA(rdata), .DS_HIT(hit), .ALU_GO(pls[8]), .ALU_OP(alu_op),
    .ALU_DST(alu_dst), .ALU_SRC(alu_src), .PTR_GO(pls[9]), .PTR_SEL(ptr_sel),
    .PTR_MODE(ptr_mode), .PTR_DISP(ptr_disp), .PTR_ADDR(ptr_addr), .STK_PUSH(pls[0]),
    .STK_POP(pls[1]), .STK_CALL(pls[2]), .STK_RET(pls[3]), .STK_RETURN_FROM_INTERRUPT_INSTR(pls[4]), .SP(sp),
    .GIE_SET(pls[5]), .GIE_CLR(pls[6]), .GIE(gie), .INSTR_DONE(pls[7]),
    .SLEEPING(sleeping), .PC(pc), .IRQ_EVT(evt), .IRQ_LVL(lvl), .IRQ_EN(irq_en),
    .IRQ_FLAG_CLR(flag_clr), .IRQ_FLAGS(flags), .VECTOR_SELECT_BIT(vsel),
    .BOOT_RESET_FUSE(fuse), .APPLICATION_LOCK_BIT(alock), .BOOT_LOCK_BIT(blk),
    .CORE_HOLD(hold), .IRQ_ENTER(enter), .VEC_ADDR(vec), .RESET_VEC(rvec));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic cmpv(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask : cmpv
  // every strobe is one cycle wide; checks land after the taking edge
  task automatic pulse(input logic [9:0] p);
    @(posedge clk);
    pls <= p;
    @(posedge clk);
    pls <= '0;
    #1;
  endtask : pulse
  task automatic dsw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    ds_addr  <= a;
    ds_wdata <= d;
    ds_we    <= 1'b1;
    @(posedge clk);
    ds_we <= 1'b0;
  endtask : dsw
  task automatic dsr(input logic [15:0] a, input logic [7:0] d, input logic h);
    @(posedge clk);
    ds_addr <= a;
    ds_re   <= 1'b1;
    @(posedge clk);
    ds_re <= 1'b0;
    #1;
    cmpv({8'h00, rdata}, {8'h00, d}, "read data");
    cmpv({15'h0, hit}, {15'h0, h}, "hit");
  endtask : dsr
  task automatic src(input logic [7:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= '0;
    @(posedge clk);
    #1;
  endtask : src
  task automatic idle_chk(input logic [7:0] fl);
    pulse(ID);
    cmpv({15'h0, hold}, 16'h0000, "no take");
    cmpv({8'h00, flags}, {8'h00, fl}, "flags kept");
  endtask : idle_chk
  task automatic take(input logic [15:0] v, input logic [7:0] fl);
    e = sp - 11'h002;
    pulse(ID);
    cmpv({14'h0, hold, gie}, 16'h0002, "entry hold");
    cmpv({5'h00, sp}, {5'h00, e}, "entry sp");
    cmpv(vec, v, "vector");
    cmpv({8'h00, flags}, {8'h00, fl}, "flags after take");
    repeat (3) @(posedge clk);
    #1;
    cmpv({15'h0, enter}, 16'h0000, "early vector");
    @(posedge clk);
    #1;
    cmpv({15'h0, enter}, 16'h0001, "vector run");
  endtask : take
  task automatic t_reset;
    cmpv({5'h00, sp}, {5'h00, ics_pkg::SP_INIT}, "reset sp");
    cmpv({14'h0, gie, hold}, 16'h0000, "reset status");
    cmpv(rvec, ics_pkg::VEC_RESET, "reset vector");
  endtask : t_reset
  task automatic t_stack;
    int dl[4] = '{-1, 1, -2, 2};
    dsw(16'h005d, 8'hfe);
    dsw(16'h005e, 8'hff);
    dsr(16'h005e, 8'h07, 1'b1);
    dsr(16'h005d, 8'hfe, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      e = sp + 11'(dl[i]);
      pulse(PU << i);
      cmpv({5'h00, sp}, {5'h00, e}, "stack step");
    end
  endtask : t_stack
  task automatic t_regs;
    logic [1:0]  pm[3] = '{2'h1, 2'h0, 2'h2};
    logic [15:0] pa[3] = '{16'h12f0, 16'h12f6, 16'h12f0};
    logic [7:0]  ar[4] = '{8'h4d, 8'h3c, 8'h10, 8'h11};
    dsw(16'h0005, 8'h3c);
    dsw(16'h0006, 8'h11);
    dsr(16'h0006, 8'h11, 1'b1);
    // add, sub, and, move chained on register 5 against register 6
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      {alu_op, alu_dst, alu_src} <= {2'(i), 5'h05, 5'h06};
      pulse(AG);
      dsr(16'h0005, ar[i], 1'b1);
    end
    dsw(16'h001c, 8'hf0);
    dsw(16'h001d, 8'h12);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      {ptr_sel, ptr_mode, ptr_disp} <= {2'h1, pm[i], (pm[i] == 2'h0) ? 6'h05 : 6'h00};
      pulse(PG);
      cmpv(ptr_addr, pa[i], "pointer address");
    end
    dsr(16'h001c, 8'hf0, 1'b1);
    dsr(16'h0060, 8'h00, 1'b0);
  endtask : t_regs
  task automatic t_irq;
    @(posedge clk);
    irq_en <= 8'h05;
    src(8'h05);
    idle_chk(8'h05);
    pulse(SE);
    cmpv({15'h0, gie}, 16'h0001, "gie set");
    idle_chk(8'h05);
    take(16'h0002, 8'h04);
  endtask : t_irq
  task automatic t_return_from_interrupt_instr;
    @(posedge clk);
    vsel <= 1'b1;
    e = sp + 11'h002;
    pulse(RI);
    cmpv({5'h00, sp}, {5'h00, e}, "return sp");
    repeat (3) @(posedge clk);
    #1;
    cmpv({14'h0, hold, gie}, 16'h0002, "returning");
    @(posedge clk);
    #1;
    cmpv({14'h0, hold, gie}, 16'h0001, "returned");
    idle_chk(8'h04);
    take(16'h1e06, 8'h00);
  endtask : t_return_from_interrupt_instr
  task automatic t_cli;
    pulse(SE);
    idle_chk(8'h00);
    src(8'h01);
    pulse(CL | ID);
    cmpv({14'h0, hold, gie}, 16'h0000, "blocked");
    @(posedge clk);
    flag_clr <= 8'h01;
    @(posedge clk);
    flag_clr <= 8'h00;
    #1;
    cmpv({8'h00, flags}, 16'h0000, "flag cleared");
  endtask : t_cli
  task automatic t_level;
    @(posedge clk);
    cond <= 8'h80;
    repeat (3) @(posedge clk);
    {cond, irq_en} <= {8'h00, 8'h80};
    pulse(SE);
    idle_chk(8'h00);
    idle_chk(8'h00);
    @(posedge clk);
    cond <= 8'h80;
    take(16'h1e10, 8'h00);
  endtask : t_level
  // fuse and lock pass two sync stages, so effects show a few edges late
  task automatic t_pins;
    @(posedge clk);
    {fuse, alock, irq_en, cond} <= {2'b11, 8'h04, 8'h00};
    src(8'h04);
    cmpv(rvec, 16'h1e00, "boot reset vector");
    pulse(SE);
    idle_chk(8'h04);
    idle_chk(8'h04);
    @(posedge clk);
    {alock, sleeping} <= 2'b01;
    e = sp - 11'h002;
    repeat (3) @(posedge clk);
    #1;
    cmpv({5'h00, sp}, {5'h00, e}, "wake sp");
    cmpv(vec, 16'h1e06, "wake vector");
    cmpv({8'h00, flags}, 16'h0000, "wake flag");
    repeat (7) @(posedge clk);
    #1;
    cmpv({14'h0, hold, enter}, 16'h0002, "wake hold");
    @(posedge clk);
    #1;
    cmpv({14'h0, hold, enter}, 16'h0001, "wake entry");
  endtask : t_pins
  initial
  begin
    {rstn, ds_we, ds_re, sleeping, vsel, fuse, alock, blk, pls} = '0;
    {ds_addr, pc, ds_wdata, irq_en, flag_clr, fire, cond} = '0;
    {alu_op, ptr_sel, ptr_mode, alu_dst, alu_src, ptr_disp} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset;
    t_stack;
    t_regs;
    t_irq;
    t_return_from_interrupt_instr;
    t_cli;
    t_level;
    t_pins;
    test_done;
  end
  // whole run is under two hundred cycles; this margin only catches a hang
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end
endmodule : tb
